// ===== core/ple_pkg.sv
package ple_pkg;
   // bank geometry
   localparam int NUM_EQ      = 8;
   localparam int NUM_EXT     = 16;
   localparam int NUM_IN      = 4;
   localparam int NUM_SIG     = NUM_EXT + NUM_EQ;
   localparam int SEL_W       = 5;
   localparam int DLY_W       = 16;
   localparam int EQ_IDX_W    = 3;

   // gate operators
   typedef enum logic [2:0] {
      PLE_OP_AND  = 3'h0,
      PLE_OP_OR   = 3'h1,
      PLE_OP_NAND = 3'h2,
      PLE_OP_NOR  = 3'h3,
      PLE_OP_XOR  = 3'h4,
      PLE_OP_XNOR = 3'h5
   } ple_op_t;

   // register map, byte addresses
   localparam logic [11:0] REG_CTRL    = 12'h000;
   localparam logic [11:0] REG_EXT_IN  = 12'h004;
   localparam logic [11:0] REG_PASS    = 12'h008;
   localparam logic [11:0] REG_RES     = 12'h00C;
   localparam logic [11:0] REG_EQ_BASE = 12'h100;
   localparam logic [11:0] REG_EQ_STEP = 12'h010;
   localparam logic [3:0]  EQ_OFS_SEL  = 4'h0;
   localparam logic [3:0]  EQ_OFS_CFG  = 4'h4;
   localparam logic [3:0]  EQ_OFS_DLY  = 4'h8;
   localparam logic [3:0]  EQ_OFS_STAT = 4'hC;

   // field positions
   localparam int SEL_LSB_RST  = 20;
   localparam int CFG_LSB_OP   = 0;
   localparam int CFG_LSB_INV  = 4;
   localparam int CFG_BIT_RINV = 8;
   localparam int DLY_LSB_FALL = 16;

   // reset values
   localparam logic [31:0] RST_SEL   = 32'h0000_0000;
   localparam logic [31:0] RST_CFG   = 32'h0000_0000;
   localparam logic [31:0] RST_DLY   = 32'h0000_0000;
   localparam logic        RST_RUN   = 1'b0;

   typedef struct packed {
      logic [SEL_W-1:0] rst_sel;
      logic [NUM_IN-1:0][SEL_W-1:0] in_sel;
   } ple_sel_t;

   typedef struct packed {
      logic              rst_inv;
      logic [NUM_IN-1:0] in_inv;
      logic              cfg_pad;
      ple_op_t           op;
   } ple_cfg_t;

   typedef struct packed {
      logic [DLY_W-1:0] fall_delay_time;
      logic [DLY_W-1:0] rise_delay_time;
   } ple_dly_t;

   typedef struct packed {
      logic              latch_n;
      logic              latched;
      logic              direct;
      logic              gate;
      logic [NUM_IN-1:0] in_state;
   } ple_stat_t;
endpackage : ple_pkg

// ===== core/ple_top.sv
// The register offsets and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - each equation takes up to four inputs, each picked from the external signals or the equation outputs.
// - each of the four inputs can be inverted on its own before the gate.
// - the gate result passes a rise delay and a separate fall delay.
// - each equation gives a direct result and a latched result at once.
// - each equation also gives the complement of the latched result.
// - the latch is cleared only by a selected reset signal that can itself be inverted.
// - with set and reset active together the reset wins and the latch goes low.
// - equations are evaluated from the first to the last index, one per cycle, pass after pass.
// - any equation output can feed any equation input in either index direction.
// - a lower equation feeding a higher one gives the value of the same pass.
// - a higher equation feeding a lower one gives the value of the previous pass.
// - results drive relay outputs and protection blocking outputs.
// - all equation inputs and outputs can be read while running.
module ple_top
   import ple_pkg::*;
#(
   parameter int N_EQ = NUM_EQ
)(
   input  wire logic               clk_i,
   input  wire logic               nrst_i,
   input  wire logic [NUM_EXT-1:0] ext_sig_i,
   output logic      [N_EQ-1:0]    relay_o,
   output logic      [N_EQ-1:0]    block_o,
   output logic      [N_EQ-1:0]    pass_strobe_o,
   input  wire logic [11:0]        s_axi_awaddr,
   input  wire logic               s_axi_awvalid,
   output logic                    s_axi_awready,
   input  wire logic [31:0]        s_axi_wdata,
   input  wire logic [3:0]         s_axi_wstrb,
   input  wire logic               s_axi_wvalid,
   output logic                    s_axi_wready,
   output logic      [1:0]         s_axi_bresp,
   output logic                    s_axi_bvalid,
   input  wire logic               s_axi_bready,
   input  wire logic [11:0]        s_axi_araddr,
   input  wire logic               s_axi_arvalid,
   output logic                    s_axi_arready,
   output logic      [31:0]        s_axi_rdata,
   output logic      [1:0]         s_axi_rresp,
   output logic                    s_axi_rvalid,
   input  wire logic               s_axi_rready
);
   // configuration and state
   logic                    run, next_run;
   logic [N_EQ-1:0]         relay_en, next_relay_en;
   logic [N_EQ-1:0]         block_en, next_block_en;
   logic [NUM_EXT-1:0]      ext_q;
   ple_sel_t                sel [N_EQ];
   ple_sel_t                next_sel [N_EQ];
   ple_cfg_t                cfg [N_EQ];
   ple_cfg_t                next_cfg [N_EQ];
   ple_dly_t                dly [N_EQ];
   ple_dly_t                next_dly [N_EQ];
   ple_stat_t               stat [N_EQ];
   ple_stat_t               next_stat [N_EQ];
   logic [DLY_W-1:0]        cnt [N_EQ];
   logic [DLY_W-1:0]        next_cnt [N_EQ];
   logic [N_EQ-1:0]         out_vec, next_out_vec;
   logic [EQ_IDX_W-1:0]     idx, next_idx;
   logic [31:0]             pass_cnt, next_pass_cnt;
   logic [N_EQ-1:0]         next_relay, next_block, next_strobe;
   // bus
   logic                    aw_hold, next_aw_hold, w_hold, next_w_hold;
   logic [11:0]             aw_addr, next_aw_addr;
   logic [31:0]             w_data, next_w_data;
   logic [3:0]              w_strb, next_w_strb;
   logic                    bvalid, next_bvalid, rvalid, next_rvalid;
   logic [1:0]              bresp, next_bresp, rresp, next_rresp;
   logic [31:0]             rdata, next_rdata;
   logic                    aw_rdy, w_rdy, ar_rdy;

   logic [NUM_SIG-1:0]      sig_vec;
   logic [NUM_IN-1:0]       in_raw, in_eff;
   logic                    gate_v, dly_v, rst_v, lat_v;
   logic                    do_wr;
   logic [31:0]             wr_old, wr_new;
   logic [EQ_IDX_W-1:0]     wr_eq, rd_eq;
   logic                    wr_in_eq, rd_in_eq;
   logic [11:0]             wr_rel, rd_rel;

   function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++)
         if (strb[b])
            r[b*8 +: 8] = new_v[b*8 +: 8];
      return r;
   endfunction : merge

   // evaluation of one equation per cycle
   always_comb
   begin
      next_idx      = idx;
      next_pass_cnt = pass_cnt;
      next_out_vec  = out_vec;
      next_strobe   = '0;
      for (int e = 0; e < N_EQ; e++)
      begin
         next_stat[e] = stat[e];
         next_cnt[e]  = cnt[e];
      end
      // out_vec updates in place, so lower ones are fresh, higher ones one pass old
      sig_vec = {out_vec, ext_q};
      for (int i = 0; i < NUM_IN; i++)
         in_raw[i] = sig_vec[sel[idx].in_sel[i]];
      in_eff = in_raw ^ cfg[idx].in_inv;
      unique case (cfg[idx].op)
         PLE_OP_AND:  gate_v = &in_eff;
         PLE_OP_OR:   gate_v = |in_eff;
         PLE_OP_NAND: gate_v = ~&in_eff;
         PLE_OP_NOR:  gate_v = ~|in_eff;
         PLE_OP_XOR:  gate_v = ^in_eff;
         PLE_OP_XNOR: gate_v = ~^in_eff;
         default:     gate_v = 1'b0;
      endcase
      // counter tracks passes the gate has differed from the output
      dly_v = stat[idx].direct;
      if (gate_v == stat[idx].direct)
         next_cnt[idx] = '0;
      else if (gate_v && cnt[idx] >= dly[idx].rise_delay_time)
      begin
         dly_v = 1'b1;
         next_cnt[idx] = '0;
      end
      else if (!gate_v && cnt[idx] >= dly[idx].fall_delay_time)
      begin
         dly_v = 1'b0;
         next_cnt[idx] = '0;
      end
      else
         next_cnt[idx] = cnt[idx] + DLY_W'(1);
      rst_v = sig_vec[sel[idx].rst_sel] ^ cfg[idx].rst_inv;
      if (rst_v)
         lat_v = 1'b0;
      else
         lat_v = stat[idx].latched | dly_v;
      if (run)
      begin
         next_stat[idx].in_state = in_raw;
         next_stat[idx].gate     = gate_v;
         next_stat[idx].direct   = dly_v;
         next_stat[idx].latched  = lat_v;
         next_stat[idx].latch_n  = ~lat_v;
         next_out_vec[idx]       = dly_v;
         next_strobe[idx]        = 1'b1;
         if (idx == EQ_IDX_W'(N_EQ - 1))
         begin
            next_idx      = '0;
            next_pass_cnt = pass_cnt + 32'h0000_0001;
         end
         else
            next_idx = idx + EQ_IDX_W'(1);
      end
      else
      begin
         next_cnt[idx] = cnt[idx];
         next_idx      = '0;
      end
      for (int e = 0; e < N_EQ; e++)
      begin
         next_relay[e] = next_stat[e].direct & relay_en[e];
         next_block[e] = next_stat[e].latched & block_en[e];
      end
   end

   // register bus
   always_comb
   begin
      next_aw_hold = aw_hold;
      next_w_hold  = w_hold;
      next_aw_addr = aw_addr;
      next_w_data  = w_data;
      next_w_strb  = w_strb;
      next_bvalid  = bvalid;
      next_bresp   = bresp;
      next_rvalid  = rvalid;
      next_rresp   = rresp;
      next_rdata   = rdata;
      next_run      = run;
      next_relay_en = relay_en;
      next_block_en = block_en;
      for (int e = 0; e < N_EQ; e++)
      begin
         next_sel[e] = sel[e];
         next_cfg[e] = cfg[e];
         next_dly[e] = dly[e];
      end
      if (s_axi_awvalid && !aw_hold)
      begin
         next_aw_hold = 1'b1;
         next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_hold)
      begin
         next_w_hold = 1'b1;
         next_w_data = s_axi_wdata;
         next_w_strb = s_axi_wstrb;
      end
      do_wr    = aw_hold && w_hold && !bvalid;
      wr_rel   = aw_addr - REG_EQ_BASE;
      wr_eq    = wr_rel[4 +: EQ_IDX_W];
      wr_in_eq = aw_addr >= REG_EQ_BASE && aw_addr < REG_EQ_BASE + 12'(N_EQ) * REG_EQ_STEP;
      wr_old   = 32'h0000_0000;
      wr_new   = 32'h0000_0000;
      if (do_wr)
      begin
         next_aw_hold = 1'b0;
         next_w_hold  = 1'b0;
         next_bvalid  = 1'b1;
         next_bresp   = 2'h0;
         if (aw_addr[1:0] != 2'h0)
            next_bresp = 2'h2;
         else if (aw_addr == REG_CTRL)
         begin
            wr_old = {8'h00, block_en, relay_en, 7'h00, run};
            wr_new = merge(wr_old, w_data, w_strb);
            next_run      = wr_new[0];
            next_relay_en = wr_new[8 +: N_EQ];
            next_block_en = wr_new[16 +: N_EQ];
         end
         else if (wr_in_eq && wr_rel[3:0] == EQ_OFS_SEL)
         begin
            wr_new = merge(32'(sel[wr_eq]), w_data, w_strb);
            next_sel[wr_eq] = ple_sel_t'(wr_new[SEL_LSB_RST + SEL_W - 1:0]);
         end
         else if (wr_in_eq && wr_rel[3:0] == EQ_OFS_CFG)
         begin
            wr_new = merge(32'(cfg[wr_eq]), w_data, w_strb);
            next_cfg[wr_eq] = ple_cfg_t'(wr_new[CFG_BIT_RINV:CFG_LSB_OP]);
         end
         else if (wr_in_eq && wr_rel[3:0] == EQ_OFS_DLY)
         begin
            wr_new = merge(dly[wr_eq], w_data, w_strb);
            next_dly[wr_eq] = wr_new;
         end
         else if (!(aw_addr == REG_EXT_IN || aw_addr == REG_PASS || aw_addr == REG_RES
                    || (wr_in_eq && wr_rel[3:0] == EQ_OFS_STAT)))
            next_bresp = 2'h2;
      end
      if (bvalid && s_axi_bready)
         next_bvalid = 1'b0;
      rd_rel   = s_axi_araddr - REG_EQ_BASE;
      rd_eq    = rd_rel[4 +: EQ_IDX_W];
      rd_in_eq = s_axi_araddr >= REG_EQ_BASE && s_axi_araddr < REG_EQ_BASE + 12'(N_EQ) * REG_EQ_STEP;
      if (s_axi_arvalid && !rvalid)
      begin
         next_rvalid = 1'b1;
         next_rresp  = 2'h0;
         next_rdata  = 32'h0000_0000;
         if (s_axi_araddr == REG_CTRL)
            next_rdata = {8'h00, block_en, relay_en, 7'h00, run};
         else if (s_axi_araddr == REG_EXT_IN)
            next_rdata = 32'(ext_q);
         else if (s_axi_araddr == REG_PASS)
            next_rdata = pass_cnt;
         else if (s_axi_araddr == REG_RES)
            next_rdata = 32'(out_vec);
         else if (rd_in_eq && rd_rel[3:0] == EQ_OFS_SEL)
            next_rdata = 32'(sel[rd_eq]);
         else if (rd_in_eq && rd_rel[3:0] == EQ_OFS_CFG)
            next_rdata = 32'(cfg[rd_eq]);
         else if (rd_in_eq && rd_rel[3:0] == EQ_OFS_DLY)
            next_rdata = dly[rd_eq];
         else if (rd_in_eq && rd_rel[3:0] == EQ_OFS_STAT)
            next_rdata = 32'(stat[rd_eq]);
         else
            next_rresp = 2'h2;
      end
      else if (rvalid && s_axi_rready)
         next_rvalid = 1'b0;
   end

   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
      begin
         run      <= RST_RUN;
         relay_en <= '0;
         block_en <= '0;
         ext_q    <= '0;
         out_vec  <= '0;
         idx      <= '0;
         pass_cnt <= '0;
         relay_o  <= '0;
         block_o  <= '0;
         pass_strobe_o <= '0;
         for (int e = 0; e < N_EQ; e++)
         begin
            sel[e]  <= ple_sel_t'(RST_SEL);
            cfg[e]  <= ple_cfg_t'(RST_CFG);
            dly[e]  <= RST_DLY;
            stat[e] <= '{latch_n: 1'b1, default: '0};
            cnt[e]  <= '0;
         end
         aw_hold <= 1'b0;
         w_hold  <= 1'b0;
         aw_addr <= '0;
         w_data  <= '0;
         w_strb  <= '0;
         bvalid  <= 1'b0;
         bresp   <= 2'h0;
         rvalid  <= 1'b0;
         rresp   <= 2'h0;
         rdata   <= '0;
         aw_rdy  <= 1'b1;
         w_rdy   <= 1'b1;
         ar_rdy  <= 1'b1;
      end
      else
      begin
         run      <= next_run;
         relay_en <= next_relay_en;
         block_en <= next_block_en;
         ext_q    <= ext_sig_i;
         out_vec  <= next_out_vec;
         idx      <= next_idx;
         pass_cnt <= next_pass_cnt;
         relay_o  <= next_relay;
         block_o  <= next_block;
         pass_strobe_o <= next_strobe;
         for (int e = 0; e < N_EQ; e++)
         begin
            sel[e]  <= next_sel[e];
            cfg[e]  <= next_cfg[e];
            dly[e]  <= next_dly[e];
            stat[e] <= next_stat[e];
            cnt[e]  <= next_cnt[e];
         end
         aw_hold <= next_aw_hold;
         w_hold  <= next_w_hold;
         aw_addr <= next_aw_addr;
         w_data  <= next_w_data;
         w_strb  <= next_w_strb;
         bvalid  <= next_bvalid;
         bresp   <= next_bresp;
         rvalid  <= next_rvalid;
         rresp   <= next_rresp;
         rdata   <= next_rdata;
         aw_rdy  <= !next_aw_hold;
         w_rdy   <= !next_w_hold;
         ar_rdy  <= !next_rvalid;
      end
   end

   assign s_axi_awready = aw_rdy;
   assign s_axi_wready  = w_rdy;
   assign s_axi_bvalid  = bvalid;
   assign s_axi_bresp   = bresp;
   assign s_axi_arready = ar_rdy;
   assign s_axi_rvalid  = rvalid;
   assign s_axi_rresp   = rresp;
   assign s_axi_rdata   = rdata;
endmodule : ple_top
`default_nettype wire

// ===== bench/ple_chk_sva.sv
`timescale 1ns/1ns
`default_nettype none
module ple_chk
   import ple_pkg::*;
#(
   parameter int N_EQ = NUM_EQ
)(
   input wire logic              clk_i,
   input wire logic              nrst_i,
   input wire logic [N_EQ-1:0]   relay_o,
   input wire logic [N_EQ-1:0]   block_o,
   input wire logic [N_EQ-1:0]   pass_strobe_o,
   input wire logic              s_axi_arvalid,
   input wire logic              s_axi_arready,
   input wire logic              s_axi_rvalid,
   input wire logic              s_axi_rready,
   input wire logic              s_axi_bvalid,
   input wire logic              s_axi_bready
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);

   a_strobe_onehot: assert property ($onehot0(pass_strobe_o))
      else $error("several equations evaluated at once");
   a_strobe_step: assert property ((pass_strobe_o != '0) && !pass_strobe_o[N_EQ-1]
      |=> pass_strobe_o == ($past(pass_strobe_o) << 1)) else $error("evaluation order broken");
   a_strobe_wrap: assert property (pass_strobe_o[N_EQ-1] ##1 (pass_strobe_o != '0)
      |-> pass_strobe_o[0]) else $error("pass does not restart at first equation");
   a_relay_slot: assert property (((relay_o ^ $past(relay_o)) & ~pass_strobe_o) == '0)
      else $error("relay moved outside its equation slot");
   a_block_slot: assert property (((block_o ^ $past(block_o)) & ~pass_strobe_o) == '0)
      else $error("block moved outside its equation slot");
   a_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_read_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read answer repeated");
   a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answer pending");
   a_write_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write answer repeated");
endmodule : ple_chk

bind ple_top ple_chk #(.N_EQ(N_EQ)) ple_chk_i (.clk_i, .nrst_i, .relay_o, .block_o, .pass_strobe_o,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_bvalid, .s_axi_bready);
`default_nettype wire

// ===== bench/ple_field.sv
`timescale 1ns/1ns
`default_nettype none
module ple_field
   import ple_pkg::*;
(
   input  wire logic               clk_i,
   input  wire logic [NUM_EXT-1:0] want_i,
   input  wire logic [NUM_EQ-1:0]  relay_i,
   output logic      [NUM_EXT-1:0] ext_sig_o,
   output logic      [NUM_EQ-1:0]  coil_o
);
   // contacts settle one clock after being moved
   always_ff @(posedge clk_i)
   begin
      ext_sig_o <= want_i;
      coil_o    <= relay_i;
   end
endmodule : ple_field
`default_nettype wire

// ===== bench/testbench.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fail_count++; \
   $display("[ERR] %0t got %0h exp %0h", $time, a, b); end end
module testbench
   import ple_pkg::*;
;
   typedef struct packed {logic [2:0] op; logic [3:0] inv; logic [3:0] ext; logic g;} ple_row_t;
   logic               clk_i = 1'h0;
   logic               nrst_i = 1'h0;
   logic [NUM_EXT-1:0] want = '0;
   logic [NUM_EXT-1:0] ext_sig;
   logic [7:0]         relay_o, block_o, strobe;
   logic [11:0]        awaddr = '0, araddr = '0;
   logic [31:0]        wdata = '0, rdata, rdv;
   logic               awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic               awready, wready, bvalid, arready, rvalid;
   logic [1:0]         bresp, rresp, rsp;
   int                 fail_count = 0, cmp_count = 0, t[8], n;
   ple_row_t           rows [11] = '{'{3'h0, 4'h0, 4'hF, 1'h1}, '{3'h0, 4'h0, 4'h7, 1'h0},
      '{3'h1, 4'h0, 4'h0, 1'h0}, '{3'h1, 4'h0, 4'h8, 1'h1}, '{3'h2, 4'h0, 4'hF, 1'h0},
      '{3'h3, 4'h0, 4'h0, 1'h1}, '{3'h4, 4'h0, 4'h7, 1'h1}, '{3'h5, 4'h0, 4'h7, 1'h0},
      '{3'h0, 4'hF, 4'h0, 1'h1}, '{3'h1, 4'h1, 4'h1, 1'h0}, '{3'h0, 4'h5, 4'hA, 1'h1}};

   always #2 clk_i = ~clk_i;

   ple_top ple_top_i (.clk_i, .nrst_i, .ext_sig_i(ext_sig), .relay_o, .block_o, .pass_strobe_o(strobe),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready));
   ple_field ple_field_i (.clk_i, .want_i(want), .relay_i(relay_o), .ext_sig_o(ext_sig), .coil_o());

   task automatic end_sim();
      $display("checks %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : end_sim

   task automatic hang(input int k);
      if (k >= 64)
      begin
         fail_count++;
         end_sim();
      end
   endtask : hang

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge clk_i);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      k = 0;
      do
      begin
         @(posedge clk_i);
         if (awvalid && awready) awvalid <= 1'h0;
         if (wvalid && wready) wvalid <= 1'h0;
         k++;
      end
      while (bvalid !== 1'h1 && k < 64);
      hang(k);
      rsp = bresp;
      bready <= 1'h0;
   endtask : wr

   task automatic rd(input logic [11:0] a);
      int k;
      @(posedge clk_i);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      k = 0;
      do
      begin
         @(posedge clk_i);
         if (arvalid && arready) arvalid <= 1'h0;
         k++;
      end
      while (rvalid !== 1'h1 && k < 64);
      hang(k);
      rsp = rresp;
      rdv = rdata;
      rready <= 1'h0;
   endtask : rd

   function automatic logic [11:0] ea(input int e, input logic [3:0] o);
      return REG_EQ_BASE + 12'(e) * REG_EQ_STEP + {8'h00, o};
   endfunction : ea

   task automatic cfg(input int e, input logic [31:0] s, input logic [31:0] c);
      wr(ea(e, EQ_OFS_SEL), s);
      wr(ea(e, EQ_OFS_CFG), c);
   endtask : cfg

   // three and a half passes (28 cycles) let inputs, delays and outputs settle
   task automatic st(input int e);
      repeat (28) @(posedge clk_i);
      rd(ea(e, EQ_OFS_STAT));
   endtask : st

   initial
   begin
      repeat (12) @(posedge clk_i);
      nrst_i <= 1'h1;
      rd(REG_CTRL);
      `CHK(rdv, RST_SEL)
      rd(ea(3, EQ_OFS_SEL));
      `CHK(rdv, RST_SEL)
      wr(ea(0, EQ_OFS_STAT), 32'hFFFF_FFFF);
      `CHK(rsp, 2'h0)
      rd(ea(0, EQ_OFS_STAT));
      `CHK(rdv, 32'h0000_0080)
      wr(12'h080, 32'h0000_0001);
      `CHK(rsp, 2'h2)
      rd(12'h080);
      `CHK({rsp, rdv}, {2'h2, 32'h0})
      $display("test reset done");
      wr(ea(0, EQ_OFS_SEL), 32'h00F1_8820);
      wr(REG_CTRL, 32'h00FF_FF01);
      foreach (rows[i])
      begin
         wr(ea(0, EQ_OFS_CFG), (32'(rows[i].inv) << CFG_LSB_INV) | 32'(rows[i].op));
         want[3:0] <= rows[i].ext;
         st(0);
         `CHK(rdv[5:0], {rows[i].g, rows[i].g, rows[i].ext})
         `CHK(relay_o[0], rows[i].g)
      end
      $display("test gates done");
      cfg(1, 32'h0052_1084, 32'h0000_0001);
      want[5:4] <= 2'h1;
      st(1);
      `CHK({rdv[7:5], block_o[1]}, 4'h7)
      want[4] <= 1'h0;
      st(1);
      `CHK({rdv[7:5], block_o[1]}, 4'h5)
      want[5:4] <= 2'h3;
      st(1);
      `CHK({rdv[7:5], block_o[1]}, 4'hA)
      wr(ea(1, EQ_OFS_CFG), 32'h0000_0101);
      st(1);
      `CHK(rdv[7:5], 3'h3)
      $display("test latch done");
      cfg(2, 32'h00F8_C631, 32'h0000_0001);
      cfg(5, 32'h00F3_18C6, 32'h0000_0001);
      cfg(3, 32'h00FA_D6B5, 32'h0000_0001);
      want[6] <= 1'h1;
      st(3);
      `CHK(relay_o & 8'h2E, 8'h2E)
      rd(REG_RES);
      `CHK(rdv[7:0], 8'h2F)
      want[6:4] <= 3'h2;
      t = '{default: -1};
      for (n = 0; n < 40; n++)
      begin
         @(posedge clk_i);
         foreach (t[i])
            if (relay_o[i] === 1'h0 && t[i] < 0) t[i] = n;
      end
      `CHK(t[2] - t[1], 1)
      `CHK(t[3] - t[5], 6)
      $display("test cascade done");
      cfg(4, 32'h00F3_9CE7, 32'h0000_0001);
      wr(ea(4, EQ_OFS_DLY), 32'h0000_0003);
      st(4);
      want[7] <= 1'h1;
      n = 0;
      while (relay_o[4] !== 1'h1 && n < 64)
      begin
         @(posedge clk_i);
         n++;
      end
      `CHK(n >= 16 && n <= 48, 1'h1)
      want[7] <= 1'h0;
      n = 0;
      while (relay_o[4] !== 1'h0 && n < 64)
      begin
         @(posedge clk_i);
         n++;
      end
      `CHK(n <= 12, 1'h1)
      $display("test delay done");
      end_sim();
   end
endmodule : testbench
`default_nettype wire
